// ==== design/sar_adc_control.v ====
// control logic of a 10-bit successive-approximation converter
`timescale 1ns/10ps
`include "sar_adc_control_consts.vh"

module sar_adc_control #(
	// input count, result width and divider counter width
	parameter N_CH   = 4,
	parameter RES_W  = 10,
	parameter DIV_W  = 6
) (
	input  wire             clk_in,
	input  wire             rst_b_in,
	input  wire [2:0]       addr_in,
	input  wire [7:0]       wr_data_in,
	input  wire             wr_in,
	input  wire             rd_in,
	output wire [7:0]       rd_data_out,
	input  wire             rc_clk_in,
	input  wire             comp_in,
	output wire [1:0]       chan_sel_out,
	output wire             ref_ext_out,
	output wire             sample_out,
	output wire [RES_W-1:0] dac_code_out,
	output wire             busy_out,
	output wire [N_CH-1:0]  dig_in_dis_out,
	output wire [N_CH-1:0]  pin_oe_b_out
);

	// ==========================================================
	// register file
	// ==========================================================
	reg [7:0]       ctrl_q;
	reg [7:0]       asel_q;
	reg [N_CH-1:0]  dir_q;
	reg [RES_W-1:0] result_q;
	reg [7:0]       rd_data_q;
	reg             busy_q;

	wire wr_ctrl = wr_in && (addr_in == `OFS_CTRL);
	wire wr_asel = wr_in && (addr_in == `OFS_ASEL);
	wire wr_dir  = wr_in && (addr_in == `OFS_DIR);

	wire       conv_on  = ctrl_q[`CTL_ON];
	wire [1:0] chan_sel = ctrl_q[`CTL_CHS_HI:`CTL_CHS_LO];
	wire [2:0] clk_sel  = asel_q[`ASL_CS_HI:`ASL_CS_LO];

	// software-held bits; the go bit itself lives in busy_q
	// writes to offsets with no register fall through every decode
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			ctrl_q <= `RST_CTRL;
			asel_q <= `RST_ASEL;
			dir_q  <= `RST_DIR;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wr_data_in;
			end
			if (wr_asel) begin
				asel_q <= wr_data_in;
			end
			if (wr_dir) begin
				dir_q <= wr_data_in[N_CH-1:0];
			end
		end
	end

	// read mux; go bit reads back the live busy state
	reg [7:0] rd_mux;
	always @* begin
		rd_mux = 8'h00;
		case (addr_in)
			`OFS_CTRL: begin
				rd_mux = ctrl_q;
				rd_mux[`CTL_GO] = busy_q;
			end
			`OFS_ASEL: begin
				rd_mux = asel_q;
				rd_mux[`ASL_RSVD] = 1'b0;
			end
			`OFS_DIR: begin
				rd_mux[N_CH-1:0] = dir_q;
			end
			`OFS_RES_HI: begin
				rd_mux[RES_W-`RES_LO_W-1:0] = result_q[RES_W-1:`RES_LO_W];
			end
			`OFS_RES_LO: begin
				rd_mux = result_q[`RES_LO_W-1:0];
			end
			default: begin
				// unmapped offsets read as zero
				rd_mux = 8'h00;
			end
		endcase
	end

	// read data stand for the single cycle after the strobe
	// zero outside the answer cycle keeps a shared read bus quiet
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			rd_data_q <= 8'h00;
		end else if (rd_in) begin
			rd_data_q <= rd_mux;
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	assign rd_data_out = rd_data_q;

	// ==========================================================
	// input synchronisers
	// ==========================================================
	// both inputs come from the analog side, off this clock
	// three stages; a level is taken only when stages two and three agree
	reg [2:0] rc_sync_q;
	reg [2:0] comp_sync_q;
	reg       rc_lvl_q;
	reg       comp_lvl_q;

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			rc_sync_q   <= 3'h0;
			comp_sync_q <= 3'h0;
			rc_lvl_q    <= 1'b0;
			comp_lvl_q  <= 1'b0;
		end else begin
			rc_sync_q   <= {rc_sync_q[1:0], rc_clk_in};
			comp_sync_q <= {comp_sync_q[1:0], comp_in};
			if (rc_sync_q[1] == rc_sync_q[2]) begin
				rc_lvl_q <= rc_sync_q[2];
			end
			if (comp_sync_q[1] == comp_sync_q[2]) begin
				comp_lvl_q <= comp_sync_q[2];
			end
		end
	end

	// rising edge of the filtered rc level
	// one clock wide, so each rc period gives exactly one tick
	wire rc_rise = !rc_lvl_q && (rc_sync_q[1] == rc_sync_q[2]) && rc_sync_q[2];

	// ==========================================================
	// conversion clock selection
	// ==========================================================
	reg [DIV_W-1:0] div_q;
	reg [DIV_W-1:0] div_mask;
	reg             tad_tick;

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			div_q <= {DIV_W{1'b0}};
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// codes 0..5 give clk/2 .. clk/64, codes 6 and 7 the rc clock;
	// the divider is never re-phased, so the first period may run short
	always @* begin
		case (clk_sel)
			`CS_DIV2:  div_mask = `DIVM_2;
			`CS_DIV4:  div_mask = `DIVM_4;
			`CS_DIV8:  div_mask = `DIVM_8;
			`CS_DIV16: div_mask = `DIVM_16;
			`CS_DIV32: div_mask = `DIVM_32;
			`CS_DIV64: div_mask = `DIVM_64;
			default:   div_mask = `DIVM_64;
		endcase
		if (clk_sel >= `CS_RC_MIN) begin
			tad_tick = rc_rise;
		end else begin
			tad_tick = ((div_q & div_mask) == div_mask);
		end
	end

	// ==========================================================
	// successive approximation sequencer
	// ==========================================================
	// idle tracks, hold seals the capacitor for one period,
	// decide settles one bit per period; busy_q is the not-idle flag
	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_HOLD   = 2'h1;
	localparam [1:0] ST_DECIDE = 2'h2;

	reg [1:0]       state_q;
	reg [1:0]       state_d;
	reg             busy_d;
	reg [3:0]       period_q;
	reg [3:0]       period_d;
	reg [RES_W-1:0] trial_q;
	reg [RES_W-1:0] trial_d;
	reg [RES_W-1:0] mask_q;
	reg [RES_W-1:0] mask_d;
	reg [RES_W-1:0] result_d;

	// a go write with the converter off is ignored; writing go low aborts
	wire start = wr_ctrl && wr_data_in[`CTL_GO] && wr_data_in[`CTL_ON] && !busy_q;
	wire abort = busy_q && ((wr_ctrl && !wr_data_in[`CTL_GO]) || !conv_on);

	// trial bit kept when the input is at or above the dac level;
	// the filter lags a few clocks, so the two fastest dividers decide on a stale level
	wire [RES_W-1:0] decided = comp_lvl_q ? trial_q : (trial_q & ~mask_q);

	// next-state logic; abort wins over a tick in the same cycle
	always @* begin
		state_d  = state_q;
		busy_d   = busy_q;
		period_d = period_q;
		trial_d  = trial_q;
		mask_d   = mask_q;
		result_d = result_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d  = ST_HOLD;
					busy_d   = 1'b1;
					period_d = `PERIOD_FIRST;
					trial_d  = `TRIAL_MSB;
					mask_d   = `TRIAL_MSB;
				end
			end
			ST_HOLD: begin
				// first period only seals the hold capacitor
				if (abort) begin
					state_d = ST_IDLE;
					busy_d  = 1'b0;
				end else if (tad_tick) begin
					state_d  = ST_DECIDE;
					period_d = period_q + 1'b1;
				end
			end
			ST_DECIDE: begin
				// msb first; the last period settles bit zero and stores
				if (abort) begin
					state_d = ST_IDLE;
					busy_d  = 1'b0;
				end else if (tad_tick) begin
					period_d = period_q + 1'b1;
					trial_d  = decided | (mask_q >> 1);
					mask_d   = mask_q >> 1;
					if (period_q == `LAST_PERIOD) begin
						result_d = decided;
						state_d  = ST_IDLE;
						busy_d   = 1'b0;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
				busy_d  = 1'b0;
			end
		endcase
	end

	// sequencer registers; an abort leaves the old result in place
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_q  <= ST_IDLE;
			busy_q   <= 1'b0;
			period_q <= `PERIOD_FIRST;
			trial_q  <= {RES_W{1'b0}};
			mask_q   <= {RES_W{1'b0}};
			result_q <= {RES_W{1'b0}};
		end else begin
			state_q  <= state_d;
			busy_q   <= busy_d;
			period_q <= period_d;
			trial_q  <= trial_d;
			mask_q   <= mask_d;
			result_q <= result_d;
		end
	end

	// ==========================================================
	// analog front end and pins
	// ==========================================================
	// hold-path selection straight from the control register
	assign chan_sel_out   = chan_sel;
	assign ref_ext_out    = ctrl_q[`CTL_REF];

	// the capacitor tracks only while the converter is on and idle
	assign sample_out     = conv_on && !busy_q;
	assign dac_code_out   = trial_q;
	assign busy_out       = busy_q;

	// analog pins lose their digital buffer to save input current
	assign dig_in_dis_out = asel_q[`ASL_ANS_HI:`ASL_ANS_LO];
	// a set direction bit means the pin is not driven
	assign pin_oe_b_out   = dir_q;

endmodule // sar_adc_control

// ==== design/sar_adc_control_consts.vh ====
// constants for the successive-approximation converter control block
`ifndef SAR_ADC_CONTROL_CONSTS_VH
`define SAR_ADC_CONTROL_CONSTS_VH
// register offsets
`define OFS_CTRL      3'h0
`define OFS_ASEL      3'h1
`define OFS_DIR       3'h2
`define OFS_RES_HI    3'h3
`define OFS_RES_LO    3'h4
// converter_control_reg fields
`define CTL_ON        0
`define CTL_GO        1
`define CTL_CHS_LO    2
`define CTL_CHS_HI    3
`define CTL_REF       6
// analog_select_reg fields
`define ASL_ANS_LO    0
`define ASL_ANS_HI    3
`define ASL_CS_LO     4
`define ASL_CS_HI     6
`define ASL_RSVD      7
// result split across the two read offsets
`define RES_LO_W      8
// reset values
`define RST_CTRL      8'h00
`define RST_ASEL      8'h0f
`define RST_DIR       4'hf
// conversion clock codes
`define CS_DIV2       3'h0
`define CS_DIV4       3'h1
`define CS_DIV8       3'h2
`define CS_DIV16      3'h3
`define CS_DIV32      3'h4
`define CS_DIV64      3'h5
`define CS_RC_MIN     3'h6
// divider tick masks, one per divider clock code (codes 0..5)
`define DIVM_2        6'h01
`define DIVM_4        6'h03
`define DIVM_8        6'h07
`define DIVM_16       6'h0f
`define DIVM_32       6'h1f
`define DIVM_64       6'h3f
// conversion length in conversion-bit periods
`define CONV_PERIODS  4'hb
`define LAST_PERIOD   4'ha
`define PERIOD_FIRST  4'h0
// trial code start (msb only)
`define TRIAL_MSB     10'h200
`endif

// ==== tb/sar_adc_control_chk.sv ====
// checker of the converter control block
`timescale 1ns/10ps
module sar_adc_control_chk (
	input wire       clk_in,
	input wire       rst_b_in,
	input wire [2:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire       wr_in,
	input wire       rd_in,
	input wire [7:0] rd_data_out,
	input wire       rc_clk_in,
	input wire [1:0] chan_sel_out,
	input wire       ref_ext_out,
	input wire       sample_out,
	input wire       busy_out,
	input wire [3:0] dig_in_dis_out,
	input wire [3:0] pin_oe_b_out
);
	// ====================
	// rc edges per conversion; clock code mirrored from the bus
	reg [4:0] n_q;
	reg       r_q;
	reg [2:0] cs_q;
	always @(posedge clk_in) begin
		r_q <= rc_clk_in;
		n_q <= (busy_out && rst_b_in) ? n_q + {4'h0, rc_clk_in && !r_q} : 5'h00;
		if (!rst_b_in)
			cs_q <= 3'h0;
		else if (wr_in && addr_in == 3'h1)
			cs_q <= wr_data_in[6:4];
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_go;
		wr_in && addr_in == 3'h0 && wr_data_in[1:0] == 2'h3 && !busy_out;
	endsequence
	sequence s_wc;
		wr_in && addr_in == 3'h0 && !busy_out;
	endsequence
	AST_START: assert property (s_go |=> busy_out && !sample_out) else $error("no start");
	AST_HOLD: assert property (s_go |=> busy_out[*8]) else $error("busy short");
	AST_SMP: assert property (busy_out |-> !sample_out) else $error("tracking");
	AST_CHS: assert property (s_wc |=> chan_sel_out == $past(wr_data_in[3:2]))
		else $error("channel");
	AST_REF: assert property (s_wc |=> ref_ext_out == $past(wr_data_in[6]))
		else $error("reference");
	AST_DIS: assert property (wr_in && addr_in == 3'h1 |=>
		dig_in_dis_out == $past(wr_data_in[3:0])) else $error("buffer");
	AST_OE: assert property (wr_in && addr_in == 3'h2 |=>
		pin_oe_b_out == $past(wr_data_in[3:0])) else $error("driver");
	AST_RD0: assert property (!rd_in |=> rd_data_out == 8'h00) else $error("read idle");
	AST_LEN: assert property (busy_out && cs_q[2:1] == 2'h3 |-> n_q <= 5'h0c)
		else $error("too long");
endmodule // sar_adc_control_chk
bind sar_adc_control sar_adc_control_chk chk_u (.clk_in, .rst_b_in, .addr_in, .wr_data_in,
	.wr_in, .rd_in, .rd_data_out, .rc_clk_in, .chan_sel_out, .ref_ext_out, .sample_out,
	.busy_out, .dig_in_dis_out, .pin_oe_b_out);

// ==== tb/sar_adc_front.sv ====
// analog front end model: shared hold, comparator, rc clock
`timescale 1ns/10ps
module sar_adc_front (
	input  wire [39:0] lvl_in,
	input  wire [1:0]  chan_in,
	input  wire        ref_in,
	input  wire        smp_in,
	input  wire [9:0]  dac_in,
	output wire        comp_out,
	output reg         rc_out
);
	reg [10:0] held;
	// external reference is half the supply, so levels read double
	always @*
		if (smp_in)
			held = {1'b0, lvl_in[chan_in*10 +: 10]} << ref_in;
	assign comp_out = held >= {1'b0, dac_in};
	// free rc oscillator, 1.6 us period
	initial begin
		rc_out = 1'b0;
		forever #800 rc_out = ~rc_out;
	end
endmodule // sar_adc_front

// ==== tb/sar_adc_control_tb.sv ====
// self-checking bench of the converter control block
`timescale 1ns/10ps
module sar_adc_control_tb;
	reg        clk_in, rst_b_in, wr_in, rd_in;
	reg  [2:0] addr_in;
	reg  [7:0] wr_data_in;
	wire [7:0] rd_data_out;
	wire [9:0] dac;
	wire [1:0] chs;
	wire [3:0] dis, oe;
	wire       rc, comp, refx, smp, busy;
	integer    err_count, checked, i, n;
	reg  [9:0] v, x;
	reg [39:0] lvl;
	sar_adc_control dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.rc_clk_in(rc), .comp_in(comp), .chan_sel_out(chs), .ref_ext_out(refx),
		.sample_out(smp), .dac_code_out(dac), .busy_out(busy),
		.dig_in_dis_out(dis), .pin_oe_b_out(oe));
	sar_adc_front fe_u (.lvl_in(lvl), .chan_in(chs), .ref_in(refx), .smp_in(smp),
		.dac_in(dac), .comp_out(comp), .rc_out(rc));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task chk(input [79:0] nm, input [9:0] e, input [9:0] g);
		checked = checked + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("MISMATCH %0s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input [2:0] a, input [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input [2:0] a, input [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk("read", {2'h0, e}, {2'h0, rd_data_out});
	endtask
	// track first so the hold holds the chosen input, then start
	task conv(input [7:0] c, input [9:0] e);
		wr(3'h0, c & 8'hfd);
		wr(3'h0, c);
		#1 n = 0;
		while (busy !== 1'b0 && n < 6000) begin
			@(posedge clk_in);
			#1 n = n + 1;
		end
		chk("done", 10'h000, {9'h000, busy});
		rd(3'h4, e[7:0]);
		rd(3'h3, {6'h00, e[9:8]});
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_in);
		err_count = err_count + 1;
		final_report;
	end
	initial begin
		err_count = 0;
		checked = 0;
		{rst_b_in, wr_in, rd_in, addr_in, wr_data_in} <= 14'h0000;
		lvl = {10'h100, 10'h013, 10'h3ff, 10'h2a5};
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd(3'h1, 8'h0f);
		rd(3'h2, 8'h0f);
		rd(3'h4, 8'h00);
		wr(3'h6, 8'hff);
		rd(3'h6, 8'h00);
		wr(3'h1, 8'h65);
		wr(3'h2, 8'h0a);
		#1 chk("dis", 10'h005, {6'h00, dis});
		chk("oe", 10'h00a, {6'h00, oe});
		$display("test regs done");
		// every input, both references, rc clock
		for (i = 0; i < 4; i = i + 1) begin
			v = lvl[i*10 +: 10];
			x = i[0] ? (v[9] ? 10'h3ff : {v[8:0], 1'b0}) : v;
			conv({1'b0, i[0], 2'h0, i[1:0], 2'h3}, x);
			chk("chan", i[1:0], {8'h00, chs});
			chk("dac", x, dac);
			chk("smp", 10'h001, {9'h000, smp});
			chk("ref", {9'h000, i[0]}, {9'h000, refx});
			chk("rclen", 10'h001, {9'h000, n > 3190 && n < 3600});
		end
		$display("test rc done");
		// divider path: too short a period for silicon, the ideal model copes
		wr(3'h1, 8'h55);
		conv(8'h03, 10'h2a5);
		chk("div64", 10'h001, {9'h000, n > 639 && n < 720});
		$display("test div done");
		// abort mid-run keeps the old result; go while off is ignored
		wr(3'h1, 8'h65);
		wr(3'h0, 8'h03);
		repeat (500) @(posedge clk_in);
		wr(3'h0, 8'h01);
		repeat (3) @(posedge clk_in);
		chk("abort", 10'h000, {9'h000, busy});
		rd(3'h4, 8'ha5);
		wr(3'h0, 8'h02);
		repeat (3) @(posedge clk_in);
		chk("off", 10'h000, {9'h000, busy});
		$display("test abort done");
		final_report;
	end
endmodule // sar_adc_control_tb
